// >>> wdwu_defines.vh
// Constants shared by the watchdog and wake-up control files.
`ifndef WDWU_DEFINES_VH
`define WDWU_DEFINES_VH
`define WDWU_ADDR_CTRL 8'h00
`define WDWU_ADDR_FLAGS 8'h04
`define WDWU_ADDR_STATUS 8'h08
`define WDWU_ADDR_WAKE_EN 8'h0c
`define WDWU_ADDR_IRQ_STAT 8'h10
`define WDWU_ADDR_IRQ_MASK 8'h14
`define WDWU_KEY_DISABLE 5'h15
`define WDWU_KEY_ENABLE 5'h0a
`define WDWU_CTRL_RESET 8'h57
`define WDWU_KEY_HI 7
`define WDWU_KEY_LO 3
`define WDWU_SEL_HI 2
`define WDWU_SEL_LO 0
`define WDWU_FLAG_WCF 0
`define WDWU_FLAG_LCF 1
`define WDWU_FLAG_LVR 2
`define WDWU_STAT_PDF 0
`define WDWU_STAT_TO 1
`define WDWU_STAT_ASLEEP 2
`define WDWU_EV_WDT 0
`define WDWU_EV_PIN 1
`define WDWU_EV_INT 2
`define WDWU_EV_FAULT 3
`define WDWU_EV_W 4
`define WDWU_SYS_CLK_KHZ 200000
`define WDWU_OSC_KHZ 32
`define WDWU_PRESC_W 15
`define WDWU_SEL_BASE 8
`define WDWU_TAP_BASE 4'h7
`define WDWU_SRESET_US 16
`endif

// >>> wdwu_tick_gen.v
// Slow oscillator tick divider derived from the system clock.
`timescale 1ns/100ps
`default_nettype none
`include "wdwu_defines.vh"
module wdwu_tick_gen #(
	parameter DIV = (`WDWU_SYS_CLK_KHZ / `WDWU_OSC_KHZ)
)
(
	input wire clk,
	input wire arst_n,
	output reg tick
);
	reg [15:0] cnt_reg;
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_reg <= 16'h0000;
			tick <= 1'b0;
		end
		else if (cnt_reg == DIV[15:0] - 16'h0001)
		begin
			cnt_reg <= 16'h0000;
			tick <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // wdwu_tick_gen
`default_nettype wire

// >>> wdwu_prescaler.v
// Fifteen-bit slow-clock counter with a selectable overflow tap.
`timescale 1ns/100ps
`default_nettype none
`include "wdwu_defines.vh"
module wdwu_prescaler #(
	parameter W = `WDWU_PRESC_W
)
(
	input wire clk,
	input wire arst_n,
	input wire tick,
	input wire run,
	input wire clear,
	input wire [2:0] sel,
	output reg ovf
);
	reg [W-1:0] cnt_reg;
	wire [W-1:0] cnt_next;
	wire [3:0] tap;
	assign cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
	assign tap = {1'b0, sel} + `WDWU_TAP_BASE;
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_reg <= {W{1'b0}};
			ovf <= 1'b0;
		end
		else if (clear)
		begin
			cnt_reg <= {W{1'b0}};
			ovf <= 1'b0;
		end
		else if (run && tick)
		begin
			cnt_reg <= cnt_next;
			// Overflow when the selected tap falls from one to zero.
			ovf <= cnt_reg[tap] & ~cnt_next[tap];
		end
		else
			ovf <= 1'b0;
	end
endmodule // wdwu_prescaler
`default_nettype wire

// >>> wdwu_top.v
// Watchdog timer and power-down wake-up control with an APB register slave.
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Leave sleep on enabled Port A fall, interrupt, or watchdog overflow.
// - Stop instruction enters sleep and sets the power-down flag.
// - Power-down flag clears only at power-up or watchdog clear instruction.
// - Overflow while asleep sets time-out, resets only program counter and stack.
// - Each Port A pin has a wake enable; pin wake resumes after stop.
// - Disabled or stack-full interrupt wake resumes after stop; stays pending.
// - Enabled interrupt with free stack level takes normal interrupt response.
// - Interrupt already pending at sleep entry cannot wake the device.
// - Counter runs from the slow oscillator, tapped by the time-out select.
// - Select codes 000 to 111 give ratios 2^8 to 2^15.
// - Key 10101 disables the watchdog, key 01010 enables it.
// - Any other key resets the chip after a delay and sets fault flag.
// - At power-on the key is 01010 and the select is 111.
// - Fault flag is set on invalid-key reset; cleared only by writing zero or at power-up.
// - Overflow while running triggers full reset and sets the time-out flag.
// - Counter cleared by invalid key, watchdog clear or stop instruction.
// - Flag bits 7 to 3 read zero; low-voltage fault flag is read-only.
// - After power-on or a full chip reset the counter is cleared and restarts when enabled.
`timescale 1ns/100ps
`default_nettype none
`include "wdwu_defines.vh"
module wdwu_top #(
	parameter PA_W = 8,
	parameter SRESET_CYC = (`WDWU_SRESET_US * `WDWU_SYS_CLK_KHZ) / 1000,
	parameter OSC_DIV = (`WDWU_SYS_CLK_KHZ / `WDWU_OSC_KHZ)
)
(
	input wire clk,
	input wire arst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire stop_instr,
	input wire wdt_clear_instr,
	input wire [PA_W-1:0] porta_pins,
	input wire int_req,
	input wire int_enabled,
	input wire stack_full,
	input wire lv_reset_event,
	input wire lv_ctrl_fault_event,
	output reg asleep,
	output reg wake_resume,
	output reg wake_int_service,
	output reg int_pending,
	output reg pc_sp_reset,
	output reg chip_reset,
	output reg irq
);
	//////////////////////////////////////////////////////////////////////////
	reg [7:0] ctrl_reg;
	reg wcf_reg;
	reg lcf_reg;
	reg lvr_reg;
	reg pdf_reg;
	reg to_reg;
	reg [PA_W-1:0] wake_en_reg;
	reg [`WDWU_EV_W-1:0] ev_reg;
	reg [`WDWU_EV_W-1:0] mask_reg;
	reg [PA_W-1:0] pa_s1_reg;
	reg [PA_W-1:0] pa_s2_reg;
	reg [PA_W-1:0] pa_s3_reg;
	reg int_s1_reg;
	reg int_s2_reg;
	reg int_blocked_reg;
	reg fault_pend_reg;
	reg [19:0] sreset_cnt_reg;
	reg after_reset_reg;
	wire tick;
	wire ovf;
	wire wr_acc;
	wire rd_acc;
	wire key_bad;
	wire wdt_on;
	wire pin_fall;
	wire int_wake;
	wire ctrl_clear;
	wire [`WDWU_EV_W-1:0] ev_set;
	wire fault_fire;
	wire [`WDWU_EV_W-1:0] ev_view;

	function key_valid;
		input [4:0] k;
		begin
			key_valid = (k == `WDWU_KEY_ENABLE) || (k == `WDWU_KEY_DISABLE);
		end
	endfunction

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign key_bad = ~key_valid(ctrl_reg[`WDWU_KEY_HI:`WDWU_KEY_LO]);
	assign wdt_on = ctrl_reg[`WDWU_KEY_HI:`WDWU_KEY_LO] == `WDWU_KEY_ENABLE;
	assign ctrl_clear = wr_acc && paddr == `WDWU_ADDR_CTRL
		&& !key_valid(pwdata[`WDWU_KEY_HI:`WDWU_KEY_LO]);
	assign pin_fall = |(pa_s3_reg & ~pa_s2_reg & wake_en_reg);
	assign int_wake = int_s2_reg & ~int_blocked_reg;
	assign fault_fire = fault_pend_reg && sreset_cnt_reg == 20'h00000;

	//////////////////////////////////////////////////////////////////////////
	wdwu_tick_gen #(
		.DIV(OSC_DIV)
	) u_tick (
		.clk(clk),
		.arst_n(arst_n),
		.tick(tick)
	);

	// Counter is cleared by invalid key, clear or stop instruction, or reset.
	wdwu_prescaler #(
		.W(`WDWU_PRESC_W)
	) u_presc (
		.clk(clk),
		.arst_n(arst_n),
		.tick(tick),
		.run(wdt_on & ~after_reset_reg),
		.clear(ctrl_clear | wdt_clear_instr | stop_instr | chip_reset | after_reset_reg),
		.sel(ctrl_reg[`WDWU_SEL_HI:`WDWU_SEL_LO]),
		.ovf(ovf)
	);

	//////////////////////////////////////////////////////////////////////////
	// Pins and the interrupt come from other domains, so two stages first.
	// Pins reset to their idle high level, so releasing reset is never taken as a fall.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pa_s1_reg <= {PA_W{1'b1}};
			pa_s2_reg <= {PA_W{1'b1}};
			pa_s3_reg <= {PA_W{1'b1}};
			int_s1_reg <= 1'b0;
			int_s2_reg <= 1'b0;
		end
		else
		begin
			pa_s1_reg <= porta_pins;
			pa_s2_reg <= pa_s1_reg;
			pa_s3_reg <= pa_s2_reg;
			int_s1_reg <= int_req;
			int_s2_reg <= int_s1_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Sleep, wake-up and watchdog reset sequencing.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			asleep <= 1'b0;
			pdf_reg <= 1'b0;
			to_reg <= 1'b0;
			int_blocked_reg <= 1'b0;
			wake_resume <= 1'b0;
			wake_int_service <= 1'b0;
			int_pending <= 1'b0;
			pc_sp_reset <= 1'b0;
			chip_reset <= 1'b0;
			after_reset_reg <= 1'b1;
		end
		else
		begin
			wake_resume <= 1'b0;
			wake_int_service <= 1'b0;
			pc_sp_reset <= 1'b0;
			chip_reset <= 1'b0;
			// The counter stays cleared for one more cycle after a full reset.
			after_reset_reg <= chip_reset;
			if (int_pending && int_enabled && !stack_full)
				int_pending <= 1'b0;
			if (wdt_clear_instr)
				pdf_reg <= 1'b0;
			if (stop_instr && !asleep)
			begin
				asleep <= 1'b1;
				pdf_reg <= 1'b1;
				to_reg <= 1'b0;
				int_blocked_reg <= int_s2_reg;
			end
			else if (asleep)
			begin
				// A request that was already high at entry stays blocked until it drops.
				if (!int_s2_reg)
					int_blocked_reg <= 1'b0;
				if (ovf)
				begin
					asleep <= 1'b0;
					to_reg <= 1'b1;
					pc_sp_reset <= 1'b1;
				end
				else if (int_wake)
				begin
					asleep <= 1'b0;
					if (int_enabled && !stack_full)
						wake_int_service <= 1'b1;
					else
					begin
						wake_resume <= 1'b1;
						int_pending <= 1'b1;
					end
				end
				else if (pin_fall)
				begin
					asleep <= 1'b0;
					wake_resume <= 1'b1;
				end
			end
			else if (ovf)
			begin
				chip_reset <= 1'b1;
				to_reg <= 1'b1;
			end
			// A full reset supersedes the partial one of a sleep overflow.
			if (fault_fire)
			begin
				chip_reset <= 1'b1;
				pc_sp_reset <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Invalid-key delay; a bad key found anywhere starts the countdown.
	// A valid key written during the countdown does not call the reset off.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fault_pend_reg <= 1'b0;
			sreset_cnt_reg <= 20'h00000;
		end
		else if (fault_pend_reg)
		begin
			if (fault_fire)
				fault_pend_reg <= 1'b0;
			else
				sreset_cnt_reg <= sreset_cnt_reg - 20'h00001;
		end
		else if (key_bad)
		begin
			fault_pend_reg <= 1'b1;
			sreset_cnt_reg <= SRESET_CYC[19:0] - 20'h00001;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	assign ev_set = {fault_fire, int_wake & asleep, pin_fall & asleep, ovf};

	// An event landing at the setup edge is reported, since the access edge clears.
	assign ev_view = ev_reg | ev_set;

	// Register writes, flag updates and event capture; set wins over clear.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_reg <= `WDWU_CTRL_RESET;
			wcf_reg <= 1'b0;
			lcf_reg <= 1'b0;
			lvr_reg <= 1'b0;
			wake_en_reg <= {PA_W{1'b0}};
			ev_reg <= {`WDWU_EV_W{1'b0}};
			mask_reg <= {`WDWU_EV_W{1'b0}};
		end
		else
		begin
			if (wr_acc)
			begin
				case (paddr)
					// A bad key is stored as written; the countdown acts on it.
					`WDWU_ADDR_CTRL: ctrl_reg <= pwdata[7:0];
					`WDWU_ADDR_FLAGS:
					begin
						if (!pwdata[`WDWU_FLAG_WCF])
							wcf_reg <= 1'b0;
						if (!pwdata[`WDWU_FLAG_LVR])
							lvr_reg <= 1'b0;
					end
					`WDWU_ADDR_WAKE_EN: wake_en_reg <= pwdata[PA_W-1:0];
					`WDWU_ADDR_IRQ_MASK: mask_reg <= pwdata[`WDWU_EV_W-1:0];
					default: ;
				endcase
			end
			if (rd_acc && paddr == `WDWU_ADDR_IRQ_STAT)
				ev_reg <= ev_set;
			else
				ev_reg <= ev_reg | ev_set;
			// The key snaps back to power-on values as the invalid-key reset fires.
			if (fault_fire)
			begin
				ctrl_reg <= `WDWU_CTRL_RESET;
				wcf_reg <= 1'b1;
			end
			if (lv_ctrl_fault_event)
				lcf_reg <= 1'b1;
			if (lv_reset_event)
				lvr_reg <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// APB answer: zero wait states, unmapped addresses give pslverr.
	// Read data is built at the setup edge and so stands through the access cycle.
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(ev_reg & mask_reg);
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable)
			begin
				case (paddr)
					`WDWU_ADDR_CTRL: prdata <= {24'h000000, ctrl_reg};
					`WDWU_ADDR_FLAGS: prdata <= {29'h00000000, lvr_reg, lcf_reg, wcf_reg};
					`WDWU_ADDR_STATUS: prdata <= {29'h00000000, asleep, to_reg, pdf_reg};
					`WDWU_ADDR_WAKE_EN: prdata <= {{(32-PA_W){1'b0}}, wake_en_reg};
					`WDWU_ADDR_IRQ_STAT: prdata <= {28'h0000000, ev_view};
					`WDWU_ADDR_IRQ_MASK: prdata <= {28'h0000000, mask_reg};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule // wdwu_top
`default_nettype wire

// >>> wdwu_props.sv
// Port-level checker for the watchdog and wake-up control block.
`timescale 1ns/100ps
`default_nettype none
module wdwu_props
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic stop_instr,
	input wire logic asleep,
	input wire logic wake_resume,
	input wire logic wake_int_service,
	input wire logic pc_sp_reset,
	input wire logic chip_reset
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!arst_n);
stop_sleep_a: assert property (stop_instr && !asleep && !chip_reset |=> asleep)
	else $error("stop did not enter sleep");
sleep_ovf_a: assert property (pc_sp_reset |-> $past(asleep) && !chip_reset)
	else $error("partial reset outside sleep");
pin_wake_a: assert property (wake_resume |-> $past(asleep) && !wake_int_service)
	else $error("resume without sleep");
int_wake_a: assert property (wake_int_service |-> $past(asleep))
	else $error("interrupt response without sleep");
reset_pulse_a: assert property (chip_reset |=> !chip_reset)
	else $error("chip reset longer than one cycle");
ready_pulse_a: assert property (pready |=> !pready)
	else $error("pready longer than one cycle");
apb_answer_a: assert property (psel && !penable |=> pready)
	else $error("no zero-wait answer");
slverr_pair_a: assert property (pslverr |-> pready && psel && penable)
	else $error("pslverr outside access");
endmodule // wdwu_props
bind wdwu_top wdwu_props props_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .stop_instr(stop_instr), .asleep(asleep),
	.wake_resume(wake_resume), .wake_int_service(wake_int_service),
	.pc_sp_reset(pc_sp_reset), .chip_reset(chip_reset));
`default_nettype wire

// >>> wdwu_tb.sv
// Self-checking testbench for the watchdog and wake-up control block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
localparam int DIV = 4;
logic clk, arst_n, psel, penable, pwrite, int_req, int_en, sfull, er;
logic [2:0] pls;
logic [7:0] paddr, pins;
logic [31:0] pwdata, prdata, q;
logic pready, pslverr, asleep, wres, wint, ipend, pcsp, crst, irq;
wire [4:0] outs = {crst, pcsp, wint, wres, asleep};
int n, checks, n_mismatch;
wdwu_top #(.PA_W(8), .SRESET_CYC(8), .OSC_DIV(DIV)) dut_u (.clk(clk), .arst_n(arst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_instr(pls[0]),
	.wdt_clear_instr(pls[1]), .porta_pins(pins), .int_req(int_req), .int_enabled(int_en),
	.stack_full(sfull), .lv_reset_event(1'b0), .lv_ctrl_fault_event(pls[2]),
	.asleep(asleep), .wake_resume(wres), .wake_int_service(wint), .int_pending(ipend),
	.pc_sp_reset(pcsp), .chip_reset(crst), .irq(irq));
always #2.5 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	checks++;
	if (g !== e)
	begin
		n_mismatch++;
		$display("Error %s expected %h seen %h", nm, e, g);
	end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
	@(posedge clk);
	penable <= 1'b1;
	do
	begin
		@(posedge clk);
	end
	while (pready !== 1'b1);
	q = prdata;
	er = pslverr;
	{psel, penable} <= 2'b00;
	@(posedge clk);
endtask
task pulse(input int k);
	pls[k] <= 1'b1;
	@(posedge clk);
	pls[k] <= 1'b0;
	@(posedge clk);
endtask
// Samples are read before the edge's own updates land, so n counts whole cycles.
task wait_out(input int k, input int lim);
	n = 0;
	while (outs[k] !== 1'b1 && n < lim)
	begin
		@(posedge clk);
		n++;
	end
endtask
task finish_test;
	$display("checks %0d mismatches %0d", checks, n_mismatch);
	if (n_mismatch == 0 && checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
task t_regs;
	apb(0, 8'h00, 0);
	chk("ctrl reset", 32'h57, q);
	apb(0, 8'h04, 0);
	chk("flags high", 0, q & 32'hf8);
	apb(0, 8'h20, 0);
	chk("unmapped err", 1, er);
	chk("unmapped data", 0, q);
endtask
task t_pin;
	apb(1, 8'h0c, 1);
	pulse(0);
	chk("asleep", 1, asleep);
	apb(0, 8'h08, 0);
	chk("pdf set", 1, q[0]);
	pins <= 8'hfe;
	wait_out(1, 20);
	chk("pin wake", 1, n < 20);
	pins <= 8'hff;
	apb(0, 8'h08, 0);
	chk("pdf kept", 1, q[0]);
	pulse(1);
	apb(0, 8'h08, 0);
	chk("pdf clear", 0, q[0]);
endtask
task t_int;
	int_en <= 1'b1;
	pulse(0);
	int_req <= 1'b1;
	wait_out(2, 20);
	chk("int service", 1, n < 20);
	// Pass 0: interrupt disabled; pass 1: enabled but the stack is full.
	for (int f = 0; f < 2; f++)
	begin
		int_req <= 1'b0;
		int_en <= f[0];
		sfull <= f[0];
		repeat (4) @(posedge clk);
		pulse(0);
		int_req <= 1'b1;
		wait_out(1, 20);
		chk("int resume", 1, n < 20);
		repeat (2) @(posedge clk);
		chk("int pending", 1, ipend);
		int_en <= 1'b1;
		sfull <= 1'b0;
		repeat (3) @(posedge clk);
		chk("pending gone", 0, ipend);
	end
endtask
task t_block;
	pulse(0);
	repeat (30) @(posedge clk);
	chk("blocked int", 1, asleep);
	int_req <= 1'b0;
	repeat (6) @(posedge clk);
	pins <= 8'hfe;
	wait_out(1, 20);
	chk("pin after block", 1, n < 20);
	pins <= 8'hff;
endtask
task t_ovf;
	// Running overflows come first, while the time-out flag is still clear.
	for (int s = 0; s < 3; s++)
	begin
		apb(1, 8'h00, 32'h50 | s);
		pulse(1);
		wait_out(4, 5000);
		chk("run ovf time", 1, n >= ((1 << (8 + s)) - (1 << s)) * DIV - 8
			&& n <= (1 << (8 + s)) * DIV + 8);
	end
	apb(0, 8'h08, 0);
	chk("run timeout flag", 1, q[1]);
	apb(1, 8'h00, 32'h50);
	pulse(0);
	wait_out(3, 1200);
	chk("sleep ovf time", 1, n >= 255 * DIV - 8 && n <= 256 * DIV + 8);
	apb(0, 8'h08, 0);
	chk("timeout flag", 1, q[1]);
	chk("pdf after ovf", 1, q[0]);
	apb(1, 8'h00, 32'ha8);
	pulse(1);
	wait_out(4, 1500);
	chk("disabled", 1500, n);
endtask
task t_key;
	apb(1, 8'h14, 32'h08);
	apb(1, 8'h00, 32'h00);
	wait_out(4, 40);
	chk("key reset delay", 1, n >= 4 && n <= 12);
	repeat (2) @(posedge clk);
	chk("irq on", 1, irq);
	apb(0, 8'h04, 0);
	chk("fault flag", 1, q[0]);
	apb(0, 8'h00, 0);
	chk("ctrl restored", 32'h57, q);
	apb(0, 8'h10, 0);
	repeat (2) @(posedge clk);
	chk("irq cleared", 0, irq);
	apb(1, 8'h04, 0);
	apb(0, 8'h04, 0);
	chk("fault clear", 0, q[0]);
	pulse(2);
	apb(1, 8'h04, 0);
	apb(0, 8'h04, 0);
	chk("lv flag ro", 1, q[1]);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
	{clk, arst_n, psel, penable, pwrite, int_req, int_en, sfull, pls} = 0;
	{paddr, pwdata, checks, n_mismatch} = 0;
	pins = 8'hff;
	repeat (3) @(posedge clk);
	arst_n <= 1'b1;
	t_regs();
	t_pin();
	t_int();
	t_block();
	t_ovf();
	t_key();
	finish_test();
end
// Budget is several times the expected run of about ten thousand cycles.
initial
begin
	#250000;
	n_mismatch++;
	finish_test();
end
endmodule // testbench
`default_nettype wire
